// ===== src/adc_serial_result_port.sv
// Serial/parallel result port with an AHB-Lite register file.
// Assumes link_clk is the host serial clock (free or framed) and that the
// mode pins and control bits are static while a word is in flight.
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port
  import result_port_pkg::*;
#(
  parameter int unsigned BITS = result_port_pkg::WORD_W
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 srst,
  input  wire logic                                 hsel,
  input  wire logic [result_port_pkg::ADDR_W-1:0]   haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [result_port_pkg::BUS_W-1:0]    hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [result_port_pkg::BUS_W-1:0]         hrdata,
  input  wire logic                                 link_clk,
  input  wire logic [result_port_pkg::SHARED_INS-1:0]  shared_pin_in,
  output logic [result_port_pkg::SHARED_OUTS-1:0]      shared_pin_out,
  output logic [result_port_pkg::SHARED_OUTS-1:0]      shared_pin_oe
);
  import result_port_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [WORD_W-1:0] code_word(
    input logic [WORD_W-1:0] raw,
    input logic              straight
  );
    code_word = straight ? raw : {~raw[WORD_W-1], raw[WORD_W-2:0]};
  endfunction

  function automatic logic sync_level(
    input logic active,
    input logic inverted
  );
    sync_level = active ^ inverted;
  endfunction

  // ==========================================================
  // Declarations
  ctrl_s               ctrl;
  logic [WORD_W-1:0]   result;
  logic [WORD_W-1:0]   coded;
  logic                conv_busy;
  logic                bus_wr;
  logic [7:0]          bus_ofs;
  logic                addr_take;
  logic [1:0]          inv_meta;
  logic [1:0]          rdc_meta;
  logic                inv_s;
  logic                rdc_s;
  logic                serial_on;
  logic                int_clk;
  logic                wr_result;
  logic                wr_cmd_conv;
  shift_e              sh_state;
  logic [1:0]          phase;
  logic [IDX_W-1:0]    bit_cnt;
  logic [WORD_W-1:0]   int_sh;
  logic                int_sclk;
  logic                int_sdo;
  logic                start_int;
  logic [WORD_W-1:0]   start_word;
  logic [SHARED_OUTS-1:0] pin_out_r;
  logic [SHARED_OUTS-1:0] pin_oe_r;
  logic [WORD_W-1:0]   pub_word;
  logic                load_tgl;
  logic                ext_pend;
  logic [1:0]          done_sync;
  logic                done_seen;
  logic                link_clk_eff;
  logic [1:0]          lrst_sync;
  logic [1:0]          ltgl_sync;
  logic                ltgl_seen;
  logic [WORD_W-1:0]   link_sh;
  logic [IDX_W-1:0]    link_idx;
  logic                link_sdo;
  logic                done_tgl;

  assign inv_s     = inv_meta[1];
  assign rdc_s     = rdc_meta[1];
  assign serial_on = ctrl.port_mode_select;
  assign int_clk   = serial_on && !ctrl.clock_source_select;
  assign coded     = code_word(result, ctrl.output_coding_select);
  assign addr_take = hsel && hready && (htrans == HTRANS_NSEQ);
  assign wr_result = bus_wr && (bus_ofs == OFS_RESULT);
  assign wr_cmd_conv = bus_wr && (bus_ofs == OFS_CMD) && hwdata[CMD_CONVERT];

  // ==========================================================
  // AHB-Lite slave: zero wait, always OKAY, read data registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_wr  <= 1'b0;
      bus_ofs <= OFS_CTRL;
    end else begin
      bus_wr  <= addr_take && hwrite;
      bus_ofs <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hrdata <= '0;
    end else if (addr_take && !hwrite) begin
      hrdata <= '0;
      if (haddr[7:0] == OFS_CTRL) begin
        hrdata[CTRL_CODING:CTRL_PORT_MODE] <= ctrl;
      end else if (haddr[7:0] == OFS_RESULT) begin
        hrdata[WORD_W-1:0] <= result;
      end else if (haddr[7:0] == OFS_STATUS) begin
        hrdata[ST_CONV_BUSY] <= conv_busy;
        hrdata[ST_INT_FRAME] <= (sh_state == SH_SHIFT);
        hrdata[ST_EXT_PEND]  <= ext_pend;
        hrdata[ST_INV_PIN]   <= inv_s;
        hrdata[ST_RDC_PIN]   <= rdc_s;
        hrdata[ST_BITS_LO +: IDX_W] <= bit_cnt;
      end
    end
  end

  // ==========================================================
  // Control and result registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= ctrl_s'(CTRL_RESET);
    end else if (bus_wr && bus_ofs == OFS_CTRL) begin
      ctrl <= ctrl_s'(hwdata[CTRL_CODING:CTRL_PORT_MODE]);
    end
  end

  // A result write stands for conversion complete
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result <= RESULT_RESET;
    end else if (wr_result) begin
      result <= hwdata[WORD_W-1:0];
    end
  end

  // Convert command sets busy, result write clears it; set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_busy <= 1'b0;
    end else if (wr_cmd_conv) begin
      conv_busy <= 1'b1;
    end else if (wr_result) begin
      conv_busy <= 1'b0;
    end
  end

  // ==========================================================
  // Pin input synchronisers (sys domain)
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inv_meta <= '0;
      rdc_meta <= '0;
    end else begin
      inv_meta <= {inv_meta[0], shared_pin_in[PIN_INV]};
      rdc_meta <= {rdc_meta[0], shared_pin_in[PIN_CHAIN]};
    end
  end
  // ==========================================================
  // Internal clock read start
  always_comb begin
    start_int  = 1'b0;
    start_word = coded;
    if (int_clk) begin
      if (rdc_s) begin
        // Previous result leaves while the next conversion runs
        start_int = wr_cmd_conv;
      end else begin
        // New result leaves only once conversion is done
        start_int  = wr_result;
        start_word = code_word(hwdata[WORD_W-1:0],
                               ctrl.output_coding_select);
      end
    end
  end

  // ==========================================================
  // Internal clock shifter: 4 phases per bit
  // Data moves at phase 0, clock rises at 1 and falls at 3, so each bit
  // is settled around both edges at the cost of a slower bit rate.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sh_state <= SH_IDLE;
      phase    <= PH_DATA;
      bit_cnt  <= '0;
      int_sh   <= '0;
      int_sdo  <= 1'b0;
      int_sclk <= 1'b0;
    end else begin
      case (sh_state)
        SH_IDLE: begin
          phase    <= PH_DATA;
          int_sclk <= 1'b0;
          if (start_int) begin
            sh_state <= SH_SHIFT;
            int_sdo  <= start_word[WORD_W-1];
            int_sh   <= {start_word[WORD_W-2:0], 1'b0};
            bit_cnt  <= IDX_W'(1);
            phase    <= PH_RISE;
          end
        end
        SH_SHIFT: begin
          phase <= phase + 2'd1;
          if (phase == PH_RISE) begin
            int_sclk <= 1'b1;
          end else if (phase == PH_FALL) begin
            int_sclk <= 1'b0;
          end
          if (phase == PH_FALL && bit_cnt == IDX_W'(BITS)) begin
            sh_state <= SH_IDLE;
          end else if (phase == PH_DATA) begin
            int_sdo <= int_sh[WORD_W-1];
            int_sh  <= {int_sh[WORD_W-2:0], 1'b0};
            bit_cnt <= bit_cnt + IDX_W'(1);
          end
        end
        default: begin
          sh_state <= SH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Shared pin drive (sys domain)
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
    end else if (!serial_on) begin
      pin_out_r <= coded[PAR_HI:PAR_LO];
      pin_oe_r  <= '1;
    end else begin
      pin_out_r                <= '0;
      pin_oe_r                 <= '0;
      pin_oe_r[PIN_SDO]        <= 1'b1;
      pin_oe_r[PIN_SYNC]       <= 1'b1;
      pin_oe_r[PIN_SCLK]       <= int_clk;
      pin_out_r[PIN_SDO]       <= int_sdo;
      pin_out_r[PIN_SCLK]      <= int_sclk ^ inv_s;
      pin_out_r[PIN_SYNC]      <= sync_level(
        int_clk && (sh_state == SH_SHIFT),
        ctrl.sync_polarity_select);
    end
  end

  // Serial data comes from the link domain when the host clocks it
  always_comb begin
    shared_pin_out = pin_out_r;
    shared_pin_oe  = pin_oe_r;
    if (serial_on && ctrl.clock_source_select) begin
      shared_pin_out[PIN_SDO] = link_sdo;
    end
  end

  // ==========================================================
  // Hand-off to link domain: word frozen while pending
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pub_word <= '0;
      load_tgl <= 1'b0;
    end else if (wr_result && serial_on && ctrl.clock_source_select
                 && !ext_pend) begin
      pub_word <= code_word(hwdata[WORD_W-1:0],
                            ctrl.output_coding_select);
      load_tgl <= ~load_tgl;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_sync <= '0;
      done_seen <= 1'b0;
    end else begin
      done_sync <= {done_sync[0], done_tgl};
      done_seen <= done_sync[1];
    end
  end

  // Pending set wins over the completion clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_pend <= 1'b0;
    end else if (wr_result && serial_on && ctrl.clock_source_select
                 && !ext_pend) begin
      ext_pend <= 1'b1;
    end else if (done_sync[1] != done_seen) begin
      ext_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Link domain: host clock, edge sense set by the invert pin
  // Invert pin is a static strap; toggling it mid-frame glitches the clock.
  assign link_clk_eff = link_clk ^ shared_pin_in[PIN_INV];

  always_ff @(posedge link_clk_eff) begin
    lrst_sync <= {lrst_sync[0], srst};
  end

  always_ff @(posedge link_clk_eff) begin
    if (lrst_sync[1]) begin
      ltgl_sync <= '0;
    end else begin
      ltgl_sync <= {ltgl_sync[0], load_tgl};
    end
  end

  // Chain pin is data of the link itself, sampled on the link edge
  always_ff @(posedge link_clk_eff) begin
    if (lrst_sync[1]) begin
      ltgl_seen <= 1'b0;
      link_sh   <= '0;
      link_idx  <= '0;
      link_sdo  <= 1'b0;
      done_tgl  <= 1'b0;
    end else if (ltgl_sync[1] != ltgl_seen) begin
      ltgl_seen <= ltgl_sync[1];
      link_sdo  <= pub_word[WORD_W-1];
      link_sh   <= {pub_word[WORD_W-2:0],
                    shared_pin_in[PIN_CHAIN]};
      link_idx  <= IDX_W'(1);
    end else begin
      link_sdo <= link_sh[WORD_W-1];
      link_sh  <= {link_sh[WORD_W-2:0], shared_pin_in[PIN_CHAIN]};
      if (link_idx != '0 && link_idx < IDX_W'(BITS)) begin
        link_idx <= link_idx + IDX_W'(1);
        if (link_idx == IDX_W'(BITS - 1)) begin
          done_tgl <= ~done_tgl;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== src/result_port_pkg.sv
// Shared constants and types for the serial result port.
// Assumes a single AHB-Lite slave with zero wait states and a 32-bit bus.
package result_port_pkg;

  // ==========================================================
  // Word and bus geometry
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BUS_W       = 32;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned SHARED_OUTS = 5;
  localparam int unsigned SHARED_INS  = 2;
  // Parallel bits carried by the shared pins (6 through 10)
  localparam int unsigned PAR_LO      = 6;
  localparam int unsigned PAR_HI      = 10;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_PORT_MODE = 0;
  localparam int unsigned CTRL_SYNC_POL  = 1;
  localparam int unsigned CTRL_CLK_SRC   = 2;
  localparam int unsigned CTRL_CODING    = 3;
  localparam int unsigned CMD_CONVERT    = 0;
  localparam int unsigned ST_CONV_BUSY   = 0;
  localparam int unsigned ST_INT_FRAME   = 1;
  localparam int unsigned ST_EXT_PEND    = 2;
  localparam int unsigned ST_INV_PIN     = 3;
  localparam int unsigned ST_RDC_PIN     = 4;
  localparam int unsigned ST_BITS_LO     = 8;

  // Shared pin slots: 0=pin6 .. 4=pin10
  localparam int unsigned PIN_INV   = 0;
  localparam int unsigned PIN_CHAIN = 1;
  localparam int unsigned PIN_SDO   = 2;
  localparam int unsigned PIN_SCLK  = 3;
  localparam int unsigned PIN_SYNC  = 4;

  // ==========================================================
  // Reset values and timing
  localparam logic [3:0]        CTRL_RESET   = 4'h8;
  localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [1:0]        HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]        PH_DATA      = 2'h0;
  localparam logic [1:0]        PH_RISE      = 2'h1;
  localparam logic [1:0]        PH_FALL      = 2'h3;

  typedef struct packed {
    logic output_coding_select;
    logic clock_source_select;
    logic sync_polarity_select;
    logic port_mode_select;
  } ctrl_s;

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b01,
    SH_SHIFT = 2'b10
  } shift_e;

endpackage

// ===== sim/adc_serial_result_port_checker.sv
// Concurrent checks on the result port's pins and bus.
// Assumes one slave on the bus and mode pins steady within a word.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port_checker
  import result_port_pkg::*;
#(
  parameter int unsigned BITS = WORD_W
) (
  input wire logic                   clk_sys,
  input wire logic                   srst,
  input wire logic                   hsel,
  input wire logic [ADDR_W-1:0]      haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [BUS_W-1:0]       hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [BUS_W-1:0]       hrdata,
  input wire logic                   link_clk,
  input wire logic [SHARED_INS-1:0]  shared_pin_in,
  input wire logic [SHARED_OUTS-1:0] shared_pin_out,
  input wire logic [SHARED_OUTS-1:0] shared_pin_oe
);
  // ==========================================
  // Shadow of the control and result registers
  ctrl_s             ctl;
  logic [WORD_W-1:0] res;
  logic [7:0]        a_q;
  logic [1:0]        age;
  logic [1:0]        k_n;
  logic [1:0]        k_p;
  logic [5:0]        nr;
  logic              wr_q;
  logic              sck_d;
  logic              sdo_n;
  logic              sdo_p;
  logic              ser_ok;
  logic              int_ok;
  logic              act;
  logic              inv;
  logic              sdo;
  logic              sck;
  assign sdo = shared_pin_out[PIN_SDO];
  assign sck = shared_pin_out[PIN_SCLK];
  assign inv = shared_pin_in[PIN_INV];
  assign act = shared_pin_out[PIN_SYNC] == !ctl.sync_polarity_select;
  // Age hides the cycles in which pins still follow the old mode
  assign ser_ok = ctl.port_mode_select && age == 2'h3;
  assign int_ok = ser_ok && !ctl.clock_source_select;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= 1'b0;
    end else if (hready) begin
      wr_q <= hsel && hwrite && htrans == HTRANS_NSEQ;
      a_q  <= haddr[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl <= CTRL_RESET;
      res <= RESULT_RESET;
    end else if (wr_q && a_q == OFS_CTRL) begin
      ctl <= hwdata[3:0];
    end else if (wr_q && a_q == OFS_RESULT) begin
      res <= hwdata[WORD_W-1:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst || (wr_q && a_q == OFS_CTRL)) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  // Counts clock moves away from idle inside a frame
  always_ff @(posedge clk_sys) begin
    sck_d <= sck;
    if (srst || !act) nr <= 6'h00;
    else if (sck != sck_d && sck != inv) nr <= nr + 6'h01;
  end
  always_ff @(negedge link_clk) begin
    sdo_n <= sdo;
    k_n   <= {ser_ok && ctl.clock_source_select, inv};
  end
  always_ff @(posedge link_clk) begin
    sdo_p <= sdo;
    k_p   <= {ser_ok && ctl.clock_source_select, inv};
  end
  // ==========================================
  // Properties
  sequence s_res_wr;
    int_ok && !act && wr_q && a_q == OFS_RESULT && !shared_pin_in[PIN_CHAIN];
  endsequence
  sequence s_sync_on;
    ##[1:3] act;
  endsequence
  property p_par;
    @(posedge clk_sys) disable iff (srst)
      !ctl.port_mode_select && age == 2'h3 && $stable(res) |->
      shared_pin_oe == 5'h1F && shared_pin_out == res[PAR_HI:PAR_LO];
  endproperty
  property p_ser_oe;
    @(posedge clk_sys) disable iff (srst)
      ser_ok |-> shared_pin_oe == {1'b1, !ctl.clock_source_select, 3'b100};
  endproperty
  property p_idle;
    @(posedge clk_sys) disable iff (srst)
      int_ok && !act && inv == $past(inv, 4) |-> sck == inv;
  endproperty
  property p_edges;
    @(posedge clk_sys) disable iff (srst)
      int_ok && act && $changed(sck) |-> $stable(sdo);
  endproperty
  property p_len;
    @(posedge clk_sys) disable iff (srst) int_ok && $fell(act) |-> nr == BITS;
  endproperty
  property p_start;
    @(posedge clk_sys) disable iff (srst) s_res_wr |-> s_sync_on;
  endproperty
  property p_reset;
    @(posedge clk_sys) srst |=> shared_pin_oe == 5'h00 && hrdata == 32'h0;
  endproperty
  property p_ext_r;
    @(posedge link_clk) disable iff (srst) k_n == 2'b10 |-> sdo == sdo_n;
  endproperty
  property p_ext_f;
    @(negedge link_clk) disable iff (srst) k_p == 2'b11 |-> sdo == sdo_p;
  endproperty
  a_par: assert property (p_par) else $error("parallel pins wrong");
  a_ser_oe: assert property (p_ser_oe) else $error("serial enables");
  a_idle: assert property (p_idle) else $error("clock idle level");
  a_edges: assert property (p_edges) else $error("data moved");
  a_len: assert property (p_len) else $error("frame length");
  a_start: assert property (p_start) else $error("no frame");
  a_reset: assert property (p_reset) else $error("reset state");
  a_ext_r: assert property (p_ext_r) else $error("data off edge");
  a_ext_f: assert property (p_ext_f) else $error("data off edge");
endmodule
bind adc_serial_result_port adc_serial_result_port_checker #(
  .BITS(BITS)
) u_chk (
  .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .link_clk(link_clk), .shared_pin_in(shared_pin_in),
  .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe)
);
`default_nettype wire

// ===== sim/result_host_model.sv
// Host side of the serial port: clocks bursts and samples data.
// Assumes the bench pulses go; the clock stands low between bursts.
`timescale 1ns/1ps
`default_nettype none
module result_host_model (
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  input  wire logic       sdo,
  input  wire logic       inv,
  output logic            link_clk,
  output logic            busy,
  output logic [63:0]     cap
);
  // ==========================================
  // Burst generator, 48 ns period
  initial begin
    link_clk = 1'b0;
    busy = 1'b0;
    cap = '0;
  end
  // Offset keeps the link unrelated in phase to the system clock
  always @(posedge go) begin
    busy = 1'b1;
    #7;
    for (int i = 0; i < pulses; i++) begin
      link_clk = 1'b1;
      if (inv) cap = {cap[62:0], sdo};
      #24;
      link_clk = 1'b0;
      if (!inv) cap = {cap[62:0], sdo};
      #24;
    end
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// ===== sim/adc_serial_result_port_tb_top.sv
// Self-checking bench for the result port.
// Assumes the bound checker and the host model beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected %0t: got %h want %h", $time, a, b); end end
module adc_serial_result_port_tb_top;
  import result_port_pkg::*;
  // ==========================================
  // Stimulus and wiring
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        go = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  pin_in = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  pulses = 8'h04;
  logic        hreadyout;
  logic        hresp;
  logic        link_clk;
  logic        busy;
  logic [4:0]  pout;
  logic [4:0]  poe;
  logic [63:0] cap;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  // Rows: invert pin, control, written word, expected pins or word
  logic [36:0] rows [4] = '{
    {1'b0, 4'h8, 16'h0540, 16'h0015}, {1'b0, 4'h9, 16'hA5C3, 16'hA5C3},
    {1'b0, 4'h1, 16'h1234, 16'h9234}, {1'b1, 4'hB, 16'h8001, 16'h8001}};
  always #50 clk_sys = ~clk_sys;
  adc_serial_result_port DUT (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_clk(link_clk), .shared_pin_in(pin_in),
    .shared_pin_out(pout), .shared_pin_oe(poe));
  result_host_model HOST (
    .go(go), .pulses(pulses), .sdo(pout[PIN_SDO]), .inv(pin_in[0]),
    .link_clk(link_clk), .busy(busy), .cap(cap));
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Collects one internally clocked frame, bits taken on clock moves
  task automatic frame(input logic pol, output logic [15:0] v, output int n);
    logic s_d;
    logic on;
    logic act;
    v = '0;
    n = 0;
    on = 1'b0;
    s_d = pout[PIN_SCLK];
    for (int t = 0; t < 400; t++) begin
      @(negedge clk_sys);
      act = pout[PIN_SYNC] === ~pol;
      if (on && !act) break;
      on = on | act;
      if (act && pout[PIN_SCLK] !== s_d && pout[PIN_SCLK] !== pin_in[0]) begin
        v = {v[14:0], pout[PIN_SDO]};
        n++;
      end
      s_d = pout[PIN_SCLK];
    end
  endtask
  task automatic burst(input logic [7:0] k);
    pulses <= k;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int t = 0; t < 200 && busy; t++) @(posedge clk_sys);
  endtask
  function automatic logic hit(logic [63:0] c, logic [16:0] p);
    for (int o = 0; o < 12; o++) if (c[o +: 17] === p) return 1'b1;
    return 1'b0;
  endfunction
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run;
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [36:0] r;
    logic [15:0] w;
    logic        ch;
    int          n;
    // Link reset needs link edges while reset is held
    go <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    go <= 1'b0;
    ahb(1'b0, OFS_CTRL, '0);
    `CHK(rd, 32'h8)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    ahb(1'b1, 8'h10, 32'h5);
    ahb(1'b0, 8'h10, '0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      pin_in <= {1'b0, r[36]};
      ahb(1'b1, OFS_CTRL, {28'h0, r[35:32]});
      ahb(1'b1, OFS_RESULT, {16'h0, r[31:16]});
      if (!r[32]) begin
        repeat (2) @(negedge clk_sys);
        `CHK(pout, r[4:0])
        `CHK(poe, 5'h1F)
      end else begin
        frame(r[33], w, n);
        `CHK(w, r[15:0])
        `CHK(n, 16)
        `CHK(pout[PIN_SYNC], r[33])
        `CHK(pout[PIN_SCLK], r[36])
        `CHK(poe[PIN_SCLK], 1'b1)
      end
    end
    pin_in <= 2'b10;
    ahb(1'b1, OFS_CTRL, 32'h9);
    ahb(1'b1, OFS_RESULT, 32'h3C5A);
    repeat (8) @(negedge clk_sys);
    `CHK(pout[PIN_SYNC], 1'b0)
    ahb(1'b1, OFS_CMD, 32'h1);
    frame(1'b0, w, n);
    `CHK(w, 16'h3C5A)
    ahb(1'b1, OFS_CTRL, 32'hD);
    for (int i = 0; i < 2; i++) begin
      w = i[0] ? 16'h5A3B : 16'hC3A4;
      ch = ~w[0];
      pin_in <= {ch, i[0]};
      ahb(1'b1, OFS_RESULT, {16'h0, w});
      burst(8'h1A);
      `CHK(hit(cap, {w, ch}), 1'b1)
      ahb(1'b0, OFS_STATUS, '0);
      `CHK(rd[ST_EXT_PEND], 1'b0)
      `CHK(poe[PIN_SCLK], 1'b0)
    end
    // Reset in the middle of an internal frame
    pin_in <= 2'b00;
    ahb(1'b1, OFS_CTRL, 32'h9);
    // Let the checker's settle window pass so the start check is armed
    repeat (2) @(posedge clk_sys);
    ahb(1'b1, OFS_RESULT, 32'hFFFF);
    repeat (20) @(posedge clk_sys);
    srst <= 1'b1;
    burst(8'h04);
    srst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK(pout, 5'h00)
    ahb(1'b0, OFS_STATUS, '0);
    `CHK(rd, 32'h0)
    complete_run;
  end
endmodule
`default_nettype wire
